// File: hw/rbr_readback_top.sv
`timescale 1ns/10ps

// Functional notes
// - Readback puts selected register on bus[11:2].
// - Readback off: select ignored, conversion data out.
// - Readback control at 111110; D9 enable, D8:0 select.
// - Select top bits zero: serial address chosen.
// - Top bits 1/2/3: fine, coarse, averager outputs.
// - Conversion data still feeds calibration during readback.
// - Soft reset bit resets chip, self-clears in 10 ns.
// - Soft reset register at 11111, reads zero.
// - Gain dB equals code/768 times 36.
// - Codes 768 and up saturate at 36 dB.
// - Every 128 codes doubles amplification.
// - Three phases derived from the two sample clocks.
// - DC restore is clamp AND pixel phase.
// - Black phase falling end captures black level.
// - Pixel bus always driven; pixel_bus_oe follows output enable.
// - Reset pin high holds chip in reset.
module rbr_readback_top (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic reset_pin,
  input wire logic wr_valid,
  input wire logic [rbr_pkg::AW-1:0] wr_addr,
  input wire logic [rbr_pkg::DW-1:0] wr_data,
  input wire logic [rbr_pkg::PIX_W-1:0] adc_data,
  input wire logic [rbr_pkg::DW-1:0] fine_offset_dac_val,
  input wire logic [rbr_pkg::DW-1:0] coarse_offset_dac_val,
  input wire logic [rbr_pkg::DW-1:0] averager_val,
  input wire logic black_sample_clock,
  input wire logic pixel_sample_clock,
  input wire logic clamp_pin,
  output logic [rbr_pkg::PIX_W-1:0] pixel_output_bus,
  output logic pixel_bus_oe,
  output logic [rbr_pkg::PIX_W-1:0] cal_data,
  output logic phi1,
  output logic phi2,
  output logic phi3,
  output logic dc_restore,
  output logic black_capture,
  output logic [rbr_pkg::GDB_W-1:0] gain_db_x64,
  output logic [2:0] gain_octave,
  output logic [6:0] gain_octave_frac,
  output logic chip_reset_active
);
  import rbr_pkg::*;

  // Serial-port registers 0 to 14, kept as one small array.
  logic [DW-1:0] sp_reg [0:NUM_SP-1];
  // Readback control register.
  logic [DW-1:0] readback_control;
  // Soft reset bit and its self-clear countdown.
  logic soft_rst_q;
  logic [3:0] soft_cnt;
  // Reset pin synchroniser; stage one feeds only stage two.
  logic rst_pin_meta;
  logic rst_pin_s2;
  // Helper bundle shared with the phase and gain modules.
  rbr_core_if core ();

  // Default value of serial register by index.
  function automatic logic [DW-1:0] sp_default(input int unsigned idx);
    sp_default = (idx == int'(ADDR_CONTROL)) ? CONTROL_RESET : ZERO_RESET;
  endfunction

  // Either reset source resets the whole register set.
  wire chip_rst = soft_rst_q || rst_pin_s2;

  // Write decode; addresses outside the map are dropped silently.
  wire sp_wr = wr_valid && (wr_addr <= ADDR_LAST_SP);
  wire rb_wr = wr_valid && (wr_addr == ADDR_READBACK);
  wire rst_hit = (wr_addr == ADDR_SOFT_RESET) || (wr_addr == ADDR_SOFT_RESET_SEL);
  wire soft_wr = wr_valid && rst_hit && wr_data[SOFT_RST_BIT];
  wire [3:0] sp_idx = wr_addr[3:0];

  // Readback control fields.
  wire rb_en = readback_control[RB_EN_BIT];
  wire [2:0] sel_hi = readback_control[SEL_HI_MSB:SEL_HI_LSB];
  wire [5:0] sel_lo = readback_control[SEL_LO_MSB:0];
  wire [DW-1:0] control_reg = sp_reg[int'(ADDR_CONTROL)];
  wire [DW-1:0] polarity_reg = sp_reg[int'(ADDR_POLARITY)];
  wire [DW-1:0] clock_reg = sp_reg[int'(ADDR_CLOCK)];

  // Serial register view by address; unmapped addresses read as zero.
  function automatic logic [DW-1:0] sp_view(input logic [5:0] a);
    logic [DW-1:0] v;
    v = ZERO_RESET;
    if (a <= ADDR_LAST_SP) begin
      v = sp_reg[a[3:0]];
    end else if (a == ADDR_READBACK) begin
      v = readback_control;
    end else if (a == ADDR_SOFT_RESET_SEL || a == ADDR_SOFT_RESET) begin
      v = {{(DW-1){1'b0}}, soft_rst_q};
    end
    return v;
  endfunction

  // Select the word shown on the bus during readback.
  logic [DW-1:0] rb_word;
  always_comb begin
    // The low six select bits only matter for serial-port registers.
    case (sel_hi)
      SEL_SERIAL: rb_word = sp_view(sel_lo);
      SEL_CAL_FINE: rb_word = fine_offset_dac_val;
      SEL_CAL_COARSE: rb_word = coarse_offset_dac_val;
      SEL_CAL_AVG: rb_word = averager_val;
      default: rb_word = ZERO_RESET;
    endcase
  end

  // Next bus value: register word on the upper ten bits, else ADC data.
  wire [PIX_W-1:0] next_bus = rb_en ? {rb_word, {RB_LSB{1'b0}}} : adc_data;

  // Reset pin is asynchronous to mclk, so it is synchronised first.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_pin_meta <= 1'b0;
      rst_pin_s2 <= 1'b0;
    end else begin
      rst_pin_meta <= reset_pin;
      rst_pin_s2 <= rst_pin_meta;
    end
  end

  // Serial registers; a chip reset wins over a write in the same cycle.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_SP; i++) begin
        sp_reg[i] <= sp_default(i);
      end
    end else if (chip_rst) begin
      for (int i = 0; i < NUM_SP; i++) begin
        sp_reg[i] <= sp_default(i);
      end
    end else if (sp_wr) begin
      sp_reg[sp_idx] <= wr_data;
    end
  end

  // Readback control register at its own serial address.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      readback_control <= ZERO_RESET;
    end else if (chip_rst) begin
      readback_control <= ZERO_RESET;
    end else if (rb_wr) begin
      readback_control <= wr_data;
    end
  end

  // Soft reset bit: set by a one, cleared after its short hold time.
  // The pin reset does not stop the countdown, so the bit always clears.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      soft_cnt <= 4'h0;
      soft_rst_q <= 1'b0;
    end else if (soft_wr) begin
      soft_cnt <= 4'(SOFT_RST_CYC - 1);
      soft_rst_q <= 1'b1;
    end else if (soft_cnt != 4'h0) begin
      soft_cnt <= soft_cnt - 4'h1;
    end else begin
      soft_rst_q <= 1'b0;
    end
  end

  // Output stage; the calibration feed never sees readback words.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pixel_output_bus <= {PIX_W{1'b0}};
      pixel_bus_oe <= 1'b0;
      cal_data <= {PIX_W{1'b0}};
      chip_reset_active <= 1'b0;
    end else begin
      pixel_output_bus <= next_bus;
      pixel_bus_oe <= control_reg[OE_BIT];
      cal_data <= adc_data;
      chip_reset_active <= chip_rst;
    end
  end

  // Hand the pins and register fields to the helpers.
  assign core.black_clk = black_sample_clock;
  assign core.pixel_clk = pixel_sample_clock;
  assign core.clamp = clamp_pin;
  assign core.pol = {polarity_reg[POL_CLAMP_BIT], polarity_reg[POL_PIXEL_SAMPLE_CLOCK_BIT],
    polarity_reg[POL_BLACK_SAMPLE_CLOCK_BIT]};
  assign core.rst_reject = clock_reg[CLK_RSTREJ_BIT];
  assign core.gain_code = sp_reg[int'(ADDR_GAIN)];

  // Phase generation from the sample clocks.
  rbr_phase_gen u_phase (
    .mclk(mclk),
    .rstn(rstn),
    .core(core.phase_mp)
  );

  // Gain code mapping.
  rbr_gain_map u_gain (
    .mclk(mclk),
    .rstn(rstn),
    .core(core.gain_mp)
  );

  // Helper outputs are already registered inside the helpers.
  assign phi1 = core.phi1;
  assign phi2 = core.phi2;
  assign phi3 = core.phi3;
  assign dc_restore = core.dc_restore;
  assign black_capture = core.black_capture;
  assign gain_db_x64 = core.gain_db_x64;
  assign gain_octave = core.gain_oct;
  assign gain_octave_frac = core.gain_frac;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // A one written to the soft reset bit.
  sequence s_soft_write;
    soft_wr;
  endsequence
  // The bit stands for one cycle and then clears.
  sequence s_soft_pulse;
    soft_rst_q ##1 !soft_rst_q;
  endsequence

  property p_soft_clear;
    s_soft_write |=> s_soft_pulse;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft reset stuck");

  property p_soft_defaults;
    soft_rst_q |=> readback_control == ZERO_RESET && control_reg == CONTROL_RESET;
  endproperty
  a_soft_defaults: assert property (p_soft_defaults) else $error("no defaults");

  property p_zero_write;
    (wr_valid && rst_hit && !wr_data[SOFT_RST_BIT] && !soft_rst_q) |=> !soft_rst_q;
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("zero write reset");

  property p_pin_hold;
    rst_pin_s2 [*2] |=> readback_control == ZERO_RESET && chip_reset_active;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin reset lost");

  property p_rb_word;
    rb_en |=> pixel_output_bus[PIX_W-1:RB_LSB] == $past(rb_word);
  endproperty
  a_rb_word: assert property (p_rb_word) else $error("readback word wrong");

  property p_normal_out;
    !rb_en |=> pixel_output_bus == $past(adc_data);
  endproperty
  a_normal_out: assert property (p_normal_out) else $error("data not passed");

  property p_cal_fine;
    (rb_en && sel_hi == SEL_CAL_FINE) |=>
      pixel_output_bus[PIX_W-1:RB_LSB] == $past(fine_offset_dac_val);
  endproperty
  a_cal_fine: assert property (p_cal_fine) else $error("fine select wrong");

  property p_cal_feed;
    rb_en |=> cal_data == $past(adc_data);
  endproperty
  a_cal_feed: assert property (p_cal_feed) else $error("cal feed broken");

  property p_oe_follow;
    $changed(control_reg[OE_BIT]) |=> pixel_bus_oe == $past(control_reg[OE_BIT]);
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("oe mismatch");

  property p_rb_write;
    (rb_wr && !chip_rst) |=> readback_control == $past(wr_data);
  endproperty
  a_rb_write: assert property (p_rb_write) else $error("readback reg write");

  // A serial select of the control address shows the control register word, not some other entry of the array.
  property p_rb_serial;
    (rb_en && sel_hi == SEL_SERIAL && sel_lo == ADDR_CONTROL) |=>
      pixel_output_bus[PIX_W-1:RB_LSB] == $past(control_reg);
  endproperty
  a_rb_serial: assert property (p_rb_serial) else $error("serial select wrong");

  // The coarse calibration code ignores the low select bits.
  property p_cal_coarse;
    (rb_en && sel_hi == SEL_CAL_COARSE) |=>
      pixel_output_bus[PIX_W-1:RB_LSB] == $past(coarse_offset_dac_val);
  endproperty
  a_cal_coarse: assert property (p_cal_coarse) else $error("coarse wrong");

  // The averager code ignores the low select bits as well.
  property p_cal_avg;
    (rb_en && sel_hi == SEL_CAL_AVG) |=>
      pixel_output_bus[PIX_W-1:RB_LSB] == $past(averager_val);
  endproperty
  a_cal_avg: assert property (p_cal_avg) else $error("averager wrong");

  // The two low bus bits carry no register data and stay at zero.
  property p_rb_low;
    rb_en |=> pixel_output_bus[RB_LSB-1:0] == '0;
  endproperty
  a_rb_low: assert property (p_rb_low) else $error("low bits set");
endmodule

// File: inc/rbr_pkg.sv
package rbr_pkg;
  // Register word, serial address and pixel bus widths.
  localparam int unsigned DW = 10;
  localparam int unsigned AW = 6;
  localparam int unsigned PIX_W = 12;
  // Serial-port register addresses.
  localparam logic [5:0] ADDR_GAIN = 6'h00;
  localparam logic [5:0] ADDR_CONTROL = 6'h08;
  localparam logic [5:0] ADDR_POLARITY = 6'h09;
  localparam logic [5:0] ADDR_CLOCK = 6'h0A;
  localparam logic [5:0] ADDR_LAST_SP = 6'h0E;
  localparam logic [5:0] ADDR_READBACK = 6'h3E;
  localparam logic [5:0] ADDR_SOFT_RESET = 6'h1F;
  localparam logic [5:0] ADDR_SOFT_RESET_SEL = 6'h3F;
  localparam int unsigned NUM_SP = 15;
  // Reset values.
  localparam logic [9:0] CONTROL_RESET = 10'h038;
  localparam logic [9:0] ZERO_RESET = 10'h000;
  // Field positions.
  localparam int unsigned OE_BIT = 5;
  localparam int unsigned RB_EN_BIT = 9;
  localparam int unsigned SEL_HI_MSB = 8;
  localparam int unsigned SEL_HI_LSB = 6;
  localparam int unsigned SEL_LO_MSB = 5;
  localparam int unsigned SOFT_RST_BIT = 0;
  localparam int unsigned POL_BLACK_SAMPLE_CLOCK_BIT = 5;
  localparam int unsigned POL_PIXEL_SAMPLE_CLOCK_BIT = 4;
  localparam int unsigned POL_CLAMP_BIT = 2;
  localparam int unsigned CLK_RSTREJ_BIT = 1;
  localparam int unsigned RB_LSB = 2;
  // Readback select codes: serial registers, then calibration values.
  localparam logic [2:0] SEL_SERIAL = 3'h0;
  localparam logic [2:0] SEL_CAL_FINE = 3'h1;
  localparam logic [2:0] SEL_CAL_COARSE = 3'h2;
  localparam logic [2:0] SEL_CAL_AVG = 3'h3;
  // Self-clear time of the soft reset bit.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SOFT_RST_NS = 10;
  localparam int unsigned SOFT_RST_CYC =
    (SOFT_RST_NS / CLK_PERIOD_NS) < 1 ? 1 : (SOFT_RST_NS / CLK_PERIOD_NS);
  // Gain law: dB = code / 768 * 36, kept in 1/64 dB units.
  localparam logic [9:0] GAIN_SAT = 10'h300;
  localparam int unsigned GAIN_DB_MAX = 36;
  localparam int unsigned GAIN_DB_FRAC = 64;
  localparam int unsigned GAIN_OCT_SHIFT = 7;
  localparam int unsigned GDB_W = 12;
endpackage

// File: inc/rbr_core_if.sv
`timescale 1ns/10ps
// Carries sampling-phase and gain signals between the top and its helpers.
interface rbr_core_if;
  logic black_clk;
  logic pixel_clk;
  logic clamp;
  logic [2:0] pol;
  logic rst_reject;
  logic phi1;
  logic phi2;
  logic phi3;
  logic dc_restore;
  logic black_capture;
  logic [9:0] gain_code;
  logic [11:0] gain_db_x64;
  logic [2:0] gain_oct;
  logic [6:0] gain_frac;
  modport phase_mp (input black_clk, pixel_clk, clamp, pol, rst_reject,
    output phi1, phi2, phi3, dc_restore, black_capture);
  modport gain_mp (input gain_code, output gain_db_x64, gain_oct, gain_frac);
  modport top_mp (output black_clk, pixel_clk, clamp, pol, rst_reject,
    gain_code, input phi1, phi2, phi3, dc_restore, black_capture,
    gain_db_x64, gain_oct, gain_frac);
endinterface

// File: hw/rbr_phase_gen.sv
`timescale 1ns/10ps
// Derives the three sampling phases and the DC restore gate from the pins.
module rbr_phase_gen (
  input wire logic mclk,
  input wire logic rstn,
  rbr_core_if.phase_mp core
);
  import rbr_pkg::*;
  // Two-stage synchronisers; the first stage feeds only the second.
  logic [2:0] meta;
  logic [2:0] sync;
  // Polarity-corrected active levels.
  wire blk_act = sync[0] == core.pol[0];
  wire pix_act = sync[1] == core.pol[1];
  wire clp_act = sync[2] == core.pol[2];
  logic phi1_q;

  // Pins come from the timing controller's domain, so they are synchronised.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta <= 3'h0;
      sync <= 3'h0;
    end else begin
      meta <= {core.clamp, core.pixel_clk, core.black_clk};
      sync <= meta;
    end
  end

  // Phases follow the sample clocks; reject is on between samples if clocked.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phi1_q <= 1'b0;
      core.phi2 <= 1'b0;
      core.phi3 <= 1'b1;
      core.dc_restore <= 1'b0;
      core.black_capture <= 1'b0;
    end else begin
      phi1_q <= blk_act;
      core.phi2 <= pix_act;
      core.phi3 <= !core.rst_reject || !(blk_act || pix_act);
      core.dc_restore <= clp_act && pix_act;
      core.black_capture <= phi1_q && !blk_act;
    end
  end
  assign core.phi1 = phi1_q;

  property p_dc_and;
    @(posedge mclk) disable iff (!rstn)
      (clp_act && pix_act) |=> core.dc_restore;
  endproperty
  a_dc_and: assert property (p_dc_and) else $error("dc restore missed");
  property p_capture_fall;
    @(posedge mclk) disable iff (!rstn)
      core.black_capture |-> $past(phi1_q, 1) && !core.phi1;
  endproperty
  a_capture_fall: assert property (p_capture_fall) else $error("bad capture");
endmodule

// File: hw/rbr_gain_map.sv
`timescale 1ns/10ps
// Maps the ten-bit gain code to dB and to an octave/fraction split.
module rbr_gain_map (
  input wire logic mclk,
  input wire logic rstn,
  rbr_core_if.gain_mp core
);
  import rbr_pkg::*;
  // Codes at or above the knee saturate, so the law stops at full gain.
  wire [9:0] sat_code = (core.gain_code >= GAIN_SAT) ? GAIN_SAT : core.gain_code;
  wire [31:0] db_full = 32'(sat_code) * GAIN_DB_MAX * GAIN_DB_FRAC / 32'(GAIN_SAT);

  // Each 128 codes is one octave: 6 dB, twice the amplification.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      core.gain_db_x64 <= 12'h000;
      core.gain_oct <= 3'h0;
      core.gain_frac <= 7'h00;
    end else begin
      core.gain_db_x64 <= db_full[GDB_W-1:0];
      core.gain_oct <= 3'(sat_code >> GAIN_OCT_SHIFT);
      core.gain_frac <= sat_code[GAIN_OCT_SHIFT-1:0];
    end
  end

  property p_gain_sat;
    @(posedge mclk) disable iff (!rstn)
      core.gain_code >= GAIN_SAT |=> core.gain_db_x64 == 12'(GAIN_DB_MAX * GAIN_DB_FRAC);
  endproperty
  a_gain_sat: assert property (p_gain_sat) else $error("gain not saturated");
  property p_gain_law;
    @(posedge mclk) disable iff (!rstn)
      core.gain_code < GAIN_SAT |=> core.gain_db_x64 == 12'(3 * $past(core.gain_code));
  endproperty
  a_gain_law: assert property (p_gain_law) else $error("gain law off");
endmodule

// File: testbench/rbr_timing_partner.sv
`timescale 1ns/10ps
// Camera timing controller model: drives the two sample clocks and the clamp.
// The clocks stand still at their inactive level between pixels.
module rbr_timing_partner (
  input wire logic mclk,
  output logic black_sample_clock,
  output logic pixel_sample_clock,
  output logic clamp_pin
);
  // All pins start inactive.
  initial begin
    black_sample_clock = 1'b0;
    pixel_sample_clock = 1'b0;
    clamp_pin = 1'b0;
  end
  // One pixel: a black phase, then a video phase, the clamp held across both.
  task automatic pixel(input int nb, input int np, input logic cl);
    @(posedge mclk);
    #1 clamp_pin = cl;
    black_sample_clock = 1'b1;
    repeat (nb) @(posedge mclk);
    #1 black_sample_clock = 1'b0;
    pixel_sample_clock = 1'b1;
    repeat (np) @(posedge mclk);
    #1 pixel_sample_clock = 1'b0;
    clamp_pin = 1'b0;
  endtask
endmodule

// File: testbench/rbr_readback_top_bench.sv
`timescale 1ns/10ps
// Self-checking bench for the readback, soft reset, gain and phase logic.
module rbr_readback_top_bench;
  import rbr_pkg::*;
  logic mclk, rstn, reset_pin, wr_valid, bsc, psc, clamp;
  logic oe, phi1, phi2, phi3, dcr, bcap, cra;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data, fine_v, coarse_v, avg_v, s;
  logic [PIX_W-1:0] adc_data, pix_bus, cal_data;
  logic [GDB_W-1:0] gdb;
  logic [2:0] goct;
  logic [6:0] gfrac;
  // Gain codes on both sides of the first octave step (07F/080) and of saturation.
  logic [9:0] codes [8] = '{10'h000, 10'h001, 10'h07F, 10'h080, 10'h100, 10'h2FF,
    10'h300, 10'h3FF};
  int n_errors = 0;
  int cmp_count = 0;
  int c1, c2, c3, cb, cd, cx;

  rbr_readback_top rbr_readback_top_inst (.mclk(mclk), .rstn(rstn), .reset_pin(reset_pin),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .adc_data(adc_data),
    .fine_offset_dac_val(fine_v), .coarse_offset_dac_val(coarse_v), .averager_val(avg_v),
    .black_sample_clock(bsc), .pixel_sample_clock(psc), .clamp_pin(clamp),
    .pixel_output_bus(pix_bus), .pixel_bus_oe(oe), .cal_data(cal_data), .phi1(phi1),
    .phi2(phi2), .phi3(phi3), .dc_restore(dcr), .black_capture(bcap), .gain_db_x64(gdb),
    .gain_octave(goct), .gain_octave_frac(gfrac), .chip_reset_active(cra));

  rbr_timing_partner rbr_timing_partner_inst (.mclk(mclk), .black_sample_clock(bsc),
    .pixel_sample_clock(psc), .clamp_pin(clamp));

  // Clock at 100 MHz.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Phase activity counters; the bench zeroes them before each pixel.
  always @(posedge mclk) begin
    c1 += phi1;
    c2 += phi2;
    c3 += !phi3;
    cb += bcap;
    cd += dcr;
    cx += dcr & !phi2;
  end

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // One write strobe, raised and lowered just after the edges.
  task automatic wr(input logic [5:0] a, input logic [9:0] d);
    @(posedge mclk);
    #1 wr_valid = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(posedge mclk);
    #1 wr_valid = 1'b0;
  endtask

  // Readback read: select, then compare the whole bus, word over two zero bits, two edges on.
  task automatic rd(input logic [8:0] sel, input logic [9:0] exp);
    wr(ADDR_READBACK, {1'b1, sel});
    cyc(2);
    chk(pix_bus, {exp, 2'b00});
  endtask

  task automatic test_done;
    $display("TB: %0d compares, %0d errors", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Bounded wait for the internal reset; a miss ends the run.
  task automatic wait_cra;
    for (int i = 0; i < 8 && cra !== 1'b1; i++) cyc(1);
    if (cra !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t: chip reset not seen", $time);
      test_done();
    end
  endtask

  // With the reject switch clocked it opens across both phases, eight cycles in all.
  task automatic run_pixel(input logic cl, input logic rej);
    c1 = 0;
    c2 = 0;
    c3 = 0;
    cb = 0;
    cd = 0;
    cx = 0;
    rbr_timing_partner_inst.pixel(4, 4, cl);
    cyc(8);
    chk(c1, 4);
    chk(c2, 4);
    chk(c3, rej ? 8 : 0);
    chk(cb, 1);
    chk(cd, cl ? 4 : 0);
    chk(cx, 0);
  endtask

  // Guard against a hang anywhere in the sequence.
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    $display("[ERR] %0t: run timed out", $time);
    test_done();
  end

  initial begin
    rstn = 1'b0;
    reset_pin = 1'b0;
    wr_valid = 1'b0;
    wr_addr = '0;
    wr_data = '0;
    adc_data = 12'h000;
    fine_v = 10'h1A5;
    coarse_v = 10'h0F3;
    avg_v = 10'h2C6;
    repeat (20) @(posedge mclk);
    #1 chk(oe, 1'b0);
    chk(phi3, 1'b1);
    rstn = 1'b1;
    adc_data = 12'hA5C;
    cyc(1);
    chk(pix_bus, 12'hA5C);
    chk(cal_data, 12'hA5C);
    chk(oe, 1'b1);
    rd(ADDR_CONTROL, CONTROL_RESET);
    rd(ADDR_SOFT_RESET_SEL, ZERO_RESET);
    rd(ADDR_READBACK, 10'h23E);
    wr(ADDR_GAIN, 10'h2B7);
    rd(ADDR_GAIN, 10'h2B7);
    rd(ADDR_LAST_SP, ZERO_RESET);
    adc_data = 12'h3C1;
    cyc(1);
    chk(cal_data, 12'h3C1);
    // Calibration codes ignore the low select bits, so they are set non-zero.
    for (int k = 1; k < 4; k++) begin
      rd({k[2:0], 6'h2A}, k == 1 ? fine_v : k == 2 ? coarse_v : avg_v);
    end
    // An undefined calibration code shows zero.
    rd(9'h100, ZERO_RESET);
    wr(ADDR_READBACK, 10'h1C8);
    adc_data = 12'h7E1;
    cyc(2);
    chk(pix_bus, 12'h7E1);
    $display("TB: readback test done");
    wr(ADDR_CONTROL, 10'h018);
    cyc(2);
    chk(oe, 1'b0);
    wr(ADDR_CONTROL, CONTROL_RESET);
    cyc(2);
    chk(oe, 1'b1);
    $display("TB: output enable test done");
    foreach (codes[i]) begin
      wr(ADDR_GAIN, codes[i]);
      cyc(4);
      s = codes[i] >= GAIN_SAT ? GAIN_SAT : codes[i];
      chk(gdb, {2'b00, s} * 12'd3);
      chk(goct, s[9:7]);
      chk(gfrac, s[6:0]);
    end
    $display("TB: gain test done");
    // Make both sample clocks and the clamp active high.
    wr(ADDR_POLARITY, 10'h034);
    cyc(4);
    run_pixel(1'b1, 1'b0);
    run_pixel(1'b0, 1'b0);
    // Clock the reset reject switch so that it opens during both phases.
    wr(ADDR_CLOCK, 10'h002);
    run_pixel(1'b1, 1'b1);
    $display("TB: phase test done");
    wr(ADDR_READBACK, 10'h208);
    // A zero in the reset bit must leave the chip running and readback on.
    wr(ADDR_SOFT_RESET, ZERO_RESET);
    cyc(2);
    chk(cra, 1'b0);
    chk(pix_bus, {CONTROL_RESET, 2'b00});
    wr(ADDR_SOFT_RESET, 10'h001);
    wait_cra();
    cyc(3);
    chk(cra, 1'b0);
    adc_data = 12'h19E;
    cyc(1);
    chk(pix_bus, 12'h19E);
    rd(ADDR_GAIN, ZERO_RESET);
    rd(ADDR_SOFT_RESET_SEL, ZERO_RESET);
    $display("TB: soft reset test done");
    wr(ADDR_GAIN, 10'h155);
    reset_pin = 1'b1;
    wait_cra();
    wr(ADDR_GAIN, 10'h0AA);
    cyc(10);
    chk(cra, 1'b1);
    reset_pin = 1'b0;
    cyc(6);
    chk(cra, 1'b0);
    rd(ADDR_GAIN, ZERO_RESET);
    $display("TB: reset pin test done");
    test_done();
  end
endmodule
